// [src/isb_consts.svh]
// register map, field positions, reset values and timing of the bus engine
`ifndef ISB_CONSTS_SVH
`define ISB_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ISB_OFF_DATA 5'h00
`define ISB_OFF_OWNADDR 5'h04
`define ISB_OFF_PRESC 5'h08
`define ISB_OFF_IDLE 5'h0C
`define ISB_OFF_CTRL1 5'h10
`define ISB_OFF_CTRL2 5'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ISB_RECOG_OFF_BIT 0
`define ISB_SA_MSB 7
`define ISB_SA_LSB 1
`define ISB_PCLK_EN_BIT 0
`define ISB_IDLE_RUN_BIT 0
`define ISB_BCNT_MSB 7
`define ISB_BCNT_LSB 5
`define ISB_ACK_BIT 4
`define ISB_DIV_MSB 2
`define ISB_DIV_LSB 0
`define ISB_MSEL_BIT 7
`define ISB_TRX_BIT 6
`define ISB_BUSY_BIT 5
`define ISB_PIN_BIT 4
`define ISB_MODE_MSB 3
`define ISB_MODE_LSB 2
`define ISB_CMD_START 4'hF
`define ISB_CMD_STOP 4'hD
`define ISB_MODE_I2C 2'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ISB_RST_BYTE 8'h00
`define ISB_RST_MODE 2'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ISB_CLK_MHZ 20
`define ISB_T_HALF_NS 400

`endif

// [src/isb_pkg.sv]
// types shared by the bus engine modules
package isb_pkg;

   typedef enum logic [2:0] {
      M_IDLE,
      M_START,
      M_LOW,
      M_HIGH,
      M_STOP1,
      M_STOP2
   } isb_mstate_t;

   typedef struct packed {
      logic msel;
      logic trx;
      logic busy;
      logic pin;
   } isb_ctl_t;

   typedef struct packed {
      logic al;
      logic aas;
      logic ad0;
      logic lrb;
   } isb_flags_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } isb_bus_t;

endpackage

// [src/isb_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module isb_sync #(
   parameter int W = 2
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta <= '1;
         dout <= '1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// [src/isb_cond.sv]
// scl edges and start/stop detection on synchronised bus lines
`timescale 1ns/1ps
module isb_cond (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl_s,
   input wire logic sda_s,
   output isb_pkg::isb_bus_t bus
);
   logic scl_q;
   logic sda_q;

   always_comb begin
      bus.scl = scl_s;
      bus.sda = sda_s;
      bus.scl_rise = scl_s & ~scl_q;
      bus.scl_fall = ~scl_s & scl_q;
      bus.start = scl_s & scl_q & sda_q & ~sda_s;
      bus.stop = scl_s & scl_q & ~sda_q & sda_s;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end
endmodule

// [src/isb_i2c_top.sv]
// byte-level i2c master/slave engine with avalon-mm registers
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "isb_consts.svh"
module isb_i2c_top (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic low_power_idle,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic bus_interface_irq
);
   localparam int HALF_BASE =
      (`ISB_T_HALF_NS * `ISB_CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [1:0] pin_s;
   isb_pkg::isb_bus_t bus;
   logic acc, next_acc;
   logic [31:0] next_rdata;
   logic [7:0] rd_mux;
   logic take;
   logic [7:0] tx_byte, next_tx_byte, rx_byte, next_rx_byte;
   logic [7:0] own_addr, next_own_addr, presc, next_presc;
   logic [7:0] idle_ctl, next_idle_ctl, cr1, next_cr1;
   logic [1:0] ifmode, next_ifmode;
   isb_pkg::isb_ctl_t ctl, next_ctl;
   isb_pkg::isb_flags_t flg, next_flg;
   isb_pkg::isb_mstate_t mstate, next_mstate;
   logic [10:0] cnt, next_cnt, half, cnt_inc;
   logic hit;
   logic [3:0] idx, next_idx, n_bits, total;
   logic [7:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
   logic skip, next_skip, in_addr, next_in_addr;
   logic selected, next_selected, give_ack, next_give_ack;
   logic start_req, next_start_req, stop_req, next_stop_req;
   logic irq, next_irq;
   logic next_scl_oe, next_sda_oe;
   logic mode_on, run, engaged, ackclk, touch, dlow;

   // ---------------------------------------------------------------
   // pin synchronisers and bus condition detector
   // ---------------------------------------------------------------
   isb_sync #(.W(2)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .din({scl_in, sda_in}),
      .dout(pin_s)
   );

   isb_cond u_cond (
      .clock(clock),
      .nrst(nrst),
      .scl_s(pin_s[1]),
      .sda_s(pin_s[0]),
      .bus(bus)
   );

   // ---------------------------------------------------------------
   // avalon slave: one wait state per access
   // ---------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~acc;
   assign take = (avs_read | avs_write) & acc;

   always_comb begin
      case (avs_address)
         `ISB_OFF_DATA: rd_mux = rx_byte;
         `ISB_OFF_OWNADDR: rd_mux = own_addr;
         `ISB_OFF_PRESC: rd_mux = presc;
         `ISB_OFF_IDLE: rd_mux = idle_ctl;
         `ISB_OFF_CTRL1: rd_mux = cr1;
         `ISB_OFF_CTRL2: rd_mux = {ctl, flg};
         default: rd_mux = 8'h00;
      endcase
      next_acc = (avs_read | avs_write) & ~acc;
      next_rdata = avs_readdata;
      if (avs_read && !acc) begin
         next_rdata = {24'h000000, rd_mux};
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         acc <= next_acc;
         avs_readdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // engine
   // ---------------------------------------------------------------
   assign mode_on = (ifmode == `ISB_MODE_I2C);
   assign run = mode_on & presc[`ISB_PCLK_EN_BIT] &
      ~(low_power_idle & ~idle_ctl[`ISB_IDLE_RUN_BIT]);
   assign engaged = ctl.msel | selected;
   assign n_bits = (in_addr || cr1[`ISB_BCNT_MSB:`ISB_BCNT_LSB] == 3'h0) ?
      4'h8 : {1'b0, cr1[`ISB_BCNT_MSB:`ISB_BCNT_LSB]};
   assign ackclk = in_addr | cr1[`ISB_ACK_BIT];
   assign total = n_bits + {3'h0, ackclk};
   assign half = 11'(HALF_BASE) << cr1[`ISB_DIV_MSB:`ISB_DIV_LSB];
   assign hit = (cnt == half - 11'h001);
   assign cnt_inc = cnt + 11'h001;

   // drive low for a zero data bit or an acknowledge slot
   always_comb begin
      dlow = 1'b0;
      if (ctl.pin && ctl.trx && engaged && idx < n_bits && !tx_shift[7]) begin
         dlow = 1'b1;
      end
      if (idx == n_bits && ackclk) begin
         if (give_ack) begin
            dlow = 1'b1;
         end else if (!in_addr && !ctl.trx && engaged &&
                      cr1[`ISB_ACK_BIT]) begin
            dlow = 1'b1;
         end
      end
   end

   always_comb begin
      next_tx_byte = tx_byte;
      next_rx_byte = rx_byte;
      next_own_addr = own_addr;
      next_presc = presc;
      next_idle_ctl = idle_ctl;
      next_cr1 = cr1;
      next_ifmode = ifmode;
      next_ctl = ctl;
      next_flg = flg;
      next_mstate = mstate;
      next_cnt = cnt;
      next_idx = idx;
      next_tx_shift = tx_shift;
      next_rx_shift = rx_shift;
      next_skip = skip;
      next_in_addr = in_addr;
      next_selected = selected;
      next_give_ack = give_ack;
      next_start_req = start_req;
      next_stop_req = stop_req;
      next_irq = irq;
      touch = 1'b0;

      // register writes and read side effects
      if (take && avs_write) begin
         case (avs_address)
            `ISB_OFF_DATA: begin
               next_tx_byte = avs_writedata[7:0];
               touch = 1'b1;
            end
            `ISB_OFF_OWNADDR: next_own_addr = avs_writedata[7:0];
            `ISB_OFF_PRESC: next_presc = avs_writedata[7:0];
            `ISB_OFF_IDLE: next_idle_ctl = avs_writedata[7:0];
            `ISB_OFF_CTRL1: next_cr1 = avs_writedata[7:0];
            `ISB_OFF_CTRL2: begin
               next_ifmode = avs_writedata[`ISB_MODE_MSB:`ISB_MODE_LSB];
               next_flg.al = 1'b0;
               if (!ctl.busy && cr1[`ISB_ACK_BIT] &&
                   avs_writedata[7:4] == `ISB_CMD_START) begin
                  next_ctl.msel = 1'b1;
                  next_ctl.trx = 1'b1;
                  next_ctl.pin = 1'b1;
                  next_start_req = 1'b1;
               end else if (ctl.busy && ctl.msel &&
                            avs_writedata[7:4] == `ISB_CMD_STOP) begin
                  next_ctl.pin = 1'b1;
                  next_stop_req = 1'b1;
               end else begin
                  next_ctl.msel = avs_writedata[`ISB_MSEL_BIT];
                  next_ctl.trx = avs_writedata[`ISB_TRX_BIT];
                  if (avs_writedata[`ISB_PIN_BIT]) begin
                     next_ctl.pin = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      if (take && avs_read && avs_address == `ISB_OFF_DATA) begin
         touch = 1'b1;
      end
      if (touch) begin
         next_ctl.pin = 1'b1;
         next_flg.al = 1'b0;
         next_flg.aas = 1'b0;
      end

      // bus conditions
      if (bus.start) begin
         next_ctl.busy = 1'b1;
         next_in_addr = 1'b1;
         next_skip = 1'b1;
         next_idx = 4'h0;
         next_selected = own_addr[`ISB_RECOG_OFF_BIT];
         next_flg.ad0 = 1'b0;
         next_give_ack = 1'b0;
         next_tx_shift = tx_byte;
      end
      if (bus.stop) begin
         next_ctl.busy = 1'b0;
         next_ctl.msel = 1'b0;
         next_ctl.trx = 1'b0;
         next_selected = 1'b0;
         next_in_addr = 1'b0;
         next_flg.ad0 = 1'b0;
         next_give_ack = 1'b0;
         next_idx = 4'h0;
      end

      // bit engine on scl edges
      if (run && (engaged || in_addr) && !bus.start && !bus.stop) begin
         if (bus.scl_rise && !skip) begin
            next_flg.lrb = bus.sda;
            if (idx < n_bits) begin
               next_rx_shift = {rx_shift[6:0], bus.sda};
               if (ctl.msel && ctl.trx && tx_shift[7] && !bus.sda) begin
                  next_flg.al = 1'b1;
                  next_ctl.msel = 1'b0;
                  next_ctl.trx = 1'b0;
                  next_selected = 1'b1;
               end
            end
         end
         if (bus.scl_fall && skip) begin
            next_skip = 1'b0;
         end else if (bus.scl_fall) begin
            next_idx = idx + 4'h1;
            if (idx < n_bits) begin
               next_tx_shift = {tx_shift[6:0], 1'b1};
            end
            if (in_addr && !ctl.msel && !own_addr[`ISB_RECOG_OFF_BIT] &&
                idx == 4'h7) begin
               if (rx_shift[7:1] == own_addr[`ISB_SA_MSB:`ISB_SA_LSB] ||
                   rx_shift == 8'h00) begin
                  next_selected = 1'b1;
                  next_give_ack = 1'b1;
                  next_flg.aas = 1'b1;
                  next_flg.ad0 = (rx_shift == 8'h00);
                  next_ctl.trx = rx_shift[0];
               end else begin
                  next_in_addr = 1'b0;
               end
            end
            if (idx + 4'h1 == total) begin
               next_ctl.pin = 1'b0;
               next_irq = 1'b1;
               next_rx_byte = rx_shift;
               next_idx = 4'h0;
               next_give_ack = 1'b0;
               next_in_addr = 1'b0;
               if (in_addr && ctl.msel && !flg.lrb) begin
                  next_ctl.trx = ~rx_shift[0];
               end
               if (own_addr[`ISB_RECOG_OFF_BIT] && !ctl.msel) begin
                  next_flg.aas = 1'b1;
               end
            end
         end
      end

      // pin release reloads the shifter and drops the request
      if (next_ctl.pin && !ctl.pin) begin
         next_irq = 1'b0;
         next_tx_shift = next_tx_byte;
      end

      // master clock generator
      if (run) begin
         case (mstate)
            isb_pkg::M_IDLE: begin
               if (start_req) begin
                  next_start_req = 1'b0;
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_START;
               end
            end
            isb_pkg::M_START: begin
               next_cnt = cnt_inc;
               if (hit) begin
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_LOW;
               end
            end
            isb_pkg::M_LOW: begin
               next_cnt = cnt_inc;
               if (!ctl.msel) begin
                  next_mstate = isb_pkg::M_IDLE;
               end else if (!ctl.pin) begin
                  next_cnt = 11'h000;
               end else if (stop_req) begin
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_STOP1;
               end else if (hit) begin
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_HIGH;
               end
            end
            isb_pkg::M_HIGH: begin
               next_cnt = cnt_inc;
               if (!ctl.msel) begin
                  next_mstate = isb_pkg::M_IDLE;
               end else if (!bus.scl) begin
                  next_cnt = 11'h000;
               end else if (hit) begin
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_LOW;
               end
            end
            isb_pkg::M_STOP1: begin
               next_cnt = cnt_inc;
               if (hit) begin
                  next_cnt = 11'h000;
                  next_mstate = isb_pkg::M_STOP2;
               end
            end
            isb_pkg::M_STOP2: begin
               next_cnt = cnt_inc;
               if (!bus.scl) begin
                  next_cnt = 11'h000;
               end else if (hit) begin
                  next_stop_req = 1'b0;
                  next_mstate = isb_pkg::M_IDLE;
               end
            end
            default: next_mstate = isb_pkg::M_IDLE;
         endcase
      end

      // pin drivers
      next_scl_oe = mode_on && (mstate == isb_pkg::M_LOW ||
         mstate == isb_pkg::M_STOP1 ||
         (selected && !ctl.msel && !ctl.pin));
      next_sda_oe = mode_on && (mstate == isb_pkg::M_START ||
         mstate == isb_pkg::M_STOP1 || mstate == isb_pkg::M_STOP2 ||
         (mstate != isb_pkg::M_IDLE || !ctl.msel) && dlow);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_byte <= `ISB_RST_BYTE;
         rx_byte <= `ISB_RST_BYTE;
         own_addr <= `ISB_RST_BYTE;
         presc <= `ISB_RST_BYTE;
         idle_ctl <= `ISB_RST_BYTE;
         cr1 <= `ISB_RST_BYTE;
         ifmode <= `ISB_RST_MODE;
         ctl <= 4'h1;
         flg <= 4'h0;
         mstate <= isb_pkg::M_IDLE;
         cnt <= 11'h000;
         idx <= 4'h0;
         tx_shift <= 8'hFF;
         rx_shift <= 8'h00;
         skip <= 1'b0;
         in_addr <= 1'b0;
         selected <= 1'b0;
         give_ack <= 1'b0;
         start_req <= 1'b0;
         stop_req <= 1'b0;
         irq <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         tx_byte <= next_tx_byte;
         rx_byte <= next_rx_byte;
         own_addr <= next_own_addr;
         presc <= next_presc;
         idle_ctl <= next_idle_ctl;
         cr1 <= next_cr1;
         ifmode <= next_ifmode;
         ctl <= next_ctl;
         flg <= next_flg;
         mstate <= next_mstate;
         cnt <= next_cnt;
         idx <= next_idx;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         skip <= next_skip;
         in_addr <= next_in_addr;
         selected <= next_selected;
         give_ack <= next_give_ack;
         start_req <= next_start_req;
         stop_req <= next_stop_req;
         irq <= next_irq;
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign bus_interface_irq = irq;
endmodule

// [testbench/isb_i2c_sva.sv]
// port assertions for the bus engine
`timescale 1ns/1ps
`include "isb_consts.svh"
module isb_i2c_sva (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic low_power_idle,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic bus_interface_irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic take;
   logic svc;
   assign take = (avs_read | avs_write) & ~avs_waitrequest;
   // data access or pin set services the word
   assign svc = take & (avs_address == `ISB_OFF_DATA
      | avs_write & avs_address == `ISB_OFF_CTRL2 & avs_writedata[4]);
   one_wait_a: assert property ((avs_read | avs_write) & avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer");
   rd_upper_a: assert property (take & avs_read
      |-> avs_readdata[31:8] == 24'h000000) else $error("upper");
   irq_scl_a: assert property (bus_interface_irq & $past(bus_interface_irq)
      |-> scl_oe) else $error("scl free");
   irq_clear_a: assert property (svc |=> !bus_interface_irq)
      else $error("irq kept");
   irq_keep_a: assert property (bus_interface_irq & !svc
      |=> bus_interface_irq) else $error("irq lost");
   irq_edge_a: assert property ($rose(bus_interface_irq) |-> !scl_in)
      else $error("irq scl high");
   scl_low_a: assert property ($rose(scl_oe) |-> scl_oe [*8])
      else $error("low short");
   scl_high_a: assert property ($fell(scl_oe) |-> !scl_oe [*8])
      else $error("high short");
   cover property ($rose(bus_interface_irq));
   cover property (take & avs_read);
   cover property (svc & bus_interface_irq);
endmodule

// [testbench/isb_slave_model.sv]
// behavioural slave on the far side of the bus
`timescale 1ns/1ps
module isb_slave_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   input wire logic clock,
   input wire logic slow,
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] tx_byte,
   output logic scl_low,
   output logic sda_low,
   output logic [7:0] rx_byte,
   output logic got
);
   logic [7:0] sh = 8'h00;
   logic sel = 1'b0;
   logic rd = 1'b0;
   logic aph = 1'b0;
   int n = 0;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      got = 1'b0;
      rx_byte = 8'h00;
   end
   // the fall that closes the start condition carries no bit
   always @(negedge sda) if (scl) begin
      n = -1;
      aph = 1'b1;
   end
   // stop frees the line
   always @(posedge sda) if (scl) begin
      sel = 1'b0;
      sda_low = 1'b0;
   end
   always @(posedge scl) if (n < 8) sh = {sh[6:0], sda};
   always @(negedge scl) begin
      n = n + 1;
      got = 1'b0;
      if (n == 8 && aph) begin
         sel = sh[7:1] == ADDR;
         rd = sh[0];
         sda_low = sel;
      end else if (n == 8) begin
         rx_byte = sh;
         got = sel & !rd;
         sda_low = got;
      end else if (n == 9) begin
         sda_low = aph & sel & rd & !tx_byte[7];
         aph = 1'b0;
         n = 0;
         if (slow) begin
            scl_low = 1'b1;
            repeat (20) @(posedge clock);
            scl_low = 1'b0;
         end
      end else
         sda_low = sel & rd & !aph & !tx_byte[7 - n];
   end
endmodule

// [testbench/isb_i2c_top_tb.sv]
// self-checking bench for the bus engine
`timescale 1ns/1ps
`include "isb_consts.svh"
module isb_i2c_top_tb;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic slow = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, scl_oe, sda_oe, bus_interface_irq;
   logic m_scl, m_sda, got;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] rx_byte, v, b;
   wire scl_w = !(scl_oe | m_scl);
   wire sda_w = !(sda_oe | m_sda);
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 16;
   logic [7:0] exp_rd[$];
   logic [7:0] exp_bus[$];
   always #25 clock = ~clock;
   isb_i2c_top isb_i2c_top_i (.clock, .nrst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .low_power_idle(1'b0), .scl_in(scl_w), .scl_out(), .scl_oe,
      .sda_in(sda_w), .sda_out(), .sda_oe, .bus_interface_irq);
   isb_slave_model isb_slave_model_i (.clock, .slow, .scl(scl_w),
      .sda(sda_w), .tx_byte, .scl_low(m_scl), .sda_low(m_sda), .rx_byte,
      .got);
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("Error %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task summarize;
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      v = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   task wirq;
      for (int k = 0; k < 3000; k++) begin
         @(negedge clock);
         if (bus_interface_irq === 1'b1) break;
      end
   endtask
   task start(input logic [7:0] a);
      acc(1'b1, `ISB_OFF_DATA, a);
      acc(1'b1, `ISB_OFF_CTRL2, 8'hF8);
      wirq();
   endtask
   task stop;
      acc(1'b1, `ISB_OFF_CTRL2, 8'hD8);
      for (int k = 0; k < 200; k++) begin
         acc(1'b0, `ISB_OFF_CTRL2, 8'h00);
         if (!v[5]) break;
      end
      chk({7'h00, v[5]}, 8'h00);
   endtask
   // ------------------------------------------------------------
   // result watchers
   // ------------------------------------------------------------
   always @(negedge clock)
      if (avs_read && avs_waitrequest === 1'b0 && exp_rd.size() > 0)
         chk(avs_readdata[7:0], exp_rd.pop_front());
   always @(posedge got)
      if (exp_bus.size() > 0)
         chk(rx_byte, exp_bus.pop_front());
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      rd(`ISB_OFF_CTRL2, 8'h10);
      rd(`ISB_OFF_DATA, 8'h00);
      acc(1'b1, `ISB_OFF_OWNADDR, 8'hA5);
      rd(`ISB_OFF_OWNADDR, 8'hA5);
      acc(1'b1, 5'h18, 8'hFF);
      rd(5'h18, 8'h00);
      rd(`ISB_OFF_PRESC, 8'h00);
      $display("register test done");
      acc(1'b1, `ISB_OFF_PRESC, 8'h01);
      acc(1'b1, `ISB_OFF_IDLE, 8'h01);
      rd(`ISB_OFF_IDLE, 8'h01);
      acc(1'b1, `ISB_OFF_CTRL1, 8'h10);
      acc(1'b1, `ISB_OFF_CTRL2, 8'h18);
      rd(`ISB_OFF_CTRL2, 8'h10);
      b = 8'($random(seed));
      start(8'hA0);
      rd(`ISB_OFF_CTRL2, 8'hE0);
      exp_bus.push_back(b);
      acc(1'b1, `ISB_OFF_DATA, b);
      wirq();
      rd(`ISB_OFF_CTRL2, 8'hE0);
      stop();
      $display("master write test done");
      start(8'h67);
      rd(`ISB_OFF_CTRL2, 8'hE1);
      stop();
      $display("no acknowledge test done");
      slow <= 1'b1;
      tx_byte <= 8'($random(seed));
      start(8'hA1);
      rd(`ISB_OFF_CTRL2, 8'hA0);
      acc(1'b1, `ISB_OFF_CTRL1, 8'h00);
      acc(1'b0, `ISB_OFF_DATA, 8'h00);
      wirq();
      stop();
      rd(`ISB_OFF_DATA, tx_byte);
      $display("master read test done");
      summarize();
   end
endmodule
bind isb_i2c_top isb_i2c_sva isb_i2c_sva_i (.clock(clock), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .low_power_idle(low_power_idle),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe),
   .bus_interface_irq(bus_interface_irq));
